// ===== rtl/act_timer.sv
`timescale 1ns/1ps
`default_nettype none
module act_timer
  import act_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        ext_count_input,
  input  wire logic        aux_osc_input,
  output logic             aux_osc_output,
  output logic             aux_osc_output_en_n,
  output logic             cmp_match_a,
  output logic             cmp_match_b,
  output logic             wake,
  output logic             irq
);
  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  logic [4:0]  timer_control_reg_r;
  logic [15:0] count_r;
  logic [15:0] count_nxt;
  logic [7:0]  count_low_byte;
  logic [7:0]  count_high_byte;
  logic        overflow_flag_r;
  logic        mask_r;
  logic [19:0] cmpa_r;
  logic [19:0] cmpb_r;
  logic        prescale_r;
  logic        pin_rise;
  logic        osc_rise;
  logic        src_rise;
  logic        tick;
  logic        timer_on;
  logic        clock_source_select;
  logic        sync_bypass;
  logic        aux_osc_enable;
  logic        sleep_mode;
  logic        wr;
  logic        wr_low;
  logic        wr_high;
  logic        sev_a;
  logic        sev_b;
  logic        sev;
  logic        wrap;
  logic        mapped;

  assign timer_on            = timer_control_reg_r[ACT_B_ON];
  assign clock_source_select = timer_control_reg_r[ACT_B_CS];
  assign sync_bypass         = timer_control_reg_r[ACT_B_BYPASS];
  assign aux_osc_enable      = timer_control_reg_r[ACT_B_OSCEN];
  assign sleep_mode          = timer_control_reg_r[ACT_B_SLEEP];
  assign count_low_byte      = count_r[7:0];
  assign count_high_byte     = count_r[15:8];

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign pready  = 1'b1;
  assign wr      = psel & penable & pwrite;
  assign wr_low  = wr & (paddr == ACT_OFF_LOW);
  assign wr_high = wr & (paddr == ACT_OFF_HIGH);
  assign mapped  = (paddr == ACT_OFF_CTRL) | (paddr == ACT_OFF_LOW) | (paddr == ACT_OFF_HIGH) |
                   (paddr == ACT_OFF_STAT) | (paddr == ACT_OFF_MASK) | (paddr == ACT_OFF_CMPA) |
                   (paddr == ACT_OFF_CMPB);
  assign pslverr = psel & penable & ~mapped;

  // ----------------------------------------------------------------
  // Clock source edges
  // ----------------------------------------------------------------
  // Both pins are sampled; the synchroniser is the only legal way in on one clock
  act_edge_det u_pin (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (ext_count_input),
    .rise    (pin_rise)
  );

  act_edge_det u_osc (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (aux_osc_input),
    .rise    (osc_rise)
  );

  // Oscillator chooses its own input over the pin
  assign src_rise = aux_osc_enable ? osc_rise : pin_rise;

  // Crystal amplifier: inverted input, driven only when enabled
  assign aux_osc_output      = ~aux_osc_input & aux_osc_enable;
  assign aux_osc_output_en_n = ~aux_osc_enable;

  // Prescaler fixed at 1:1; one stage kept so a count write can clear it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale_r <= 1'b0;
    end else if (wr_low | wr_high) begin
      prescale_r <= 1'b0;
    end else begin
      prescale_r <= src_rise;
    end
  end

  // Bypass mode keeps counting in sleep; synced mode stalls in sleep.
  // With one system clock the bypass path still sees each pin edge once,
  // which is the best an edge-sampled design can offer.
  always_comb begin
    tick = 1'b0;
    if (timer_on & clock_source_select & (sync_bypass | ~sleep_mode)) begin
      tick = prescale_r;
    end
  end

  // ----------------------------------------------------------------
  // Compare units and special event trigger
  // ----------------------------------------------------------------
  // Async mode is no time base for compares
  assign cmp_match_a = (count_r == cmpa_r[15:0]) & ~(clock_source_select & sync_bypass);
  assign cmp_match_b = (count_r == cmpb_r[15:0]) & ~(clock_source_select & sync_bypass);
  assign sev_a = cmp_match_a & (cmpa_r[ACT_CMP_MODE_LSB +: 4] == ACT_MODE_SPECIAL);
  assign sev_b = cmp_match_b & (cmpb_r[ACT_CMP_MODE_LSB +: 4] == ACT_MODE_SPECIAL);
  // Trigger not performed in async mode, which the host must accept
  assign sev   = sev_a | sev_b;
  assign wrap  = tick & (count_r == 16'hFFFF);

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  always_comb begin
    count_nxt = count_r;
    if (wr_low) begin
      count_nxt = {count_r[15:8], pwdata[7:0]};
    end else if (wr_high) begin
      count_nxt = {pwdata[7:0], count_r[7:0]};
    end else if (sev) begin
      count_nxt = ACT_COUNT_INIT;
    end else if (tick) begin
      count_nxt = count_r + 16'h0001;
    end
  end

  // Count is not touched by reset; plain clocked register
  always_ff @(posedge pclk) begin
    count_r <= count_nxt;
  end

  // ----------------------------------------------------------------
  // Control, compare and mask registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_control_reg_r <= ACT_CTRL_RST;
      mask_r              <= 1'b0;
      cmpa_r              <= ACT_CMP_RST;
      cmpb_r              <= ACT_CMP_RST;
    end else if (wr) begin
      if (paddr == ACT_OFF_CTRL) timer_control_reg_r <= pwdata[4:0];
      if (paddr == ACT_OFF_MASK) mask_r <= pwdata[ACT_B_OVF];
      if (paddr == ACT_OFF_CMPA) cmpa_r <= pwdata[19:0];
      if (paddr == ACT_OFF_CMPB) cmpb_r <= pwdata[19:0];
    end
  end

  // ----------------------------------------------------------------
  // Overflow flag: set wins over write-one-to-clear
  // ----------------------------------------------------------------
  // A trigger reset never reaches this flag, only a true wrap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_flag_r <= 1'b0;
    end else if (wrap & ~wr_low & ~wr_high & ~sev) begin
      overflow_flag_r <= 1'b1;
    end else if (wr & (paddr == ACT_OFF_STAT) & pwdata[ACT_B_OVF]) begin
      overflow_flag_r <= 1'b0;
    end
  end

  assign irq  = overflow_flag_r & mask_r;
  assign wake = irq & sleep_mode;

  // ----------------------------------------------------------------
  // Read data, registered on the setup cycle
  // ----------------------------------------------------------------
  // Whole byte captured from one count value, so no torn byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel & ~penable & ~pwrite) begin
      unique case (paddr)
        ACT_OFF_CTRL: prdata <= {27'h0000000, timer_control_reg_r};
        ACT_OFF_LOW:  prdata <= {24'h000000, count_low_byte};
        ACT_OFF_HIGH: prdata <= {24'h000000, count_high_byte};
        ACT_OFF_STAT: prdata <= {31'h00000000, overflow_flag_r};
        ACT_OFF_MASK: prdata <= {31'h00000000, mask_r};
        ACT_OFF_CMPA: prdata <= {12'h000, cmpa_r};
        ACT_OFF_CMPB: prdata <= {12'h000, cmpb_r};
        default:      prdata <= 32'h00000000;
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== rtl/act_pkg.sv
package act_pkg;
  // Register byte offsets
  localparam logic [11:0] ACT_OFF_CTRL  = 12'h000;
  localparam logic [11:0] ACT_OFF_LOW   = 12'h004;
  localparam logic [11:0] ACT_OFF_HIGH  = 12'h008;
  localparam logic [11:0] ACT_OFF_STAT  = 12'h00C;
  localparam logic [11:0] ACT_OFF_MASK  = 12'h010;
  localparam logic [11:0] ACT_OFF_CMPA  = 12'h014;
  localparam logic [11:0] ACT_OFF_CMPB  = 12'h018;
  // Control bit positions
  localparam int ACT_B_ON     = 0;
  localparam int ACT_B_CS     = 1;
  localparam int ACT_B_BYPASS = 2;
  localparam int ACT_B_OSCEN  = 3;
  localparam int ACT_B_SLEEP  = 4;
  // Status / mask bit positions
  localparam int ACT_B_OVF    = 0;
  // Compare register fields: value [15:0], mode [19:16]
  localparam int ACT_CMP_MODE_LSB = 16;
  localparam logic [3:0]  ACT_MODE_SPECIAL = 4'hB;
  // Reset values
  localparam logic [4:0]  ACT_CTRL_RST = 5'h00;
  localparam logic [15:0] ACT_COUNT_INIT = 16'h0000;
  localparam logic [19:0] ACT_CMP_RST  = 20'h00000;
  // Oscillator rating
  localparam int ACT_OSC_MAX_KHZ = 200;
  localparam int ACT_PCLK_KHZ    = 40000;
endpackage

// ===== rtl/act_edge_det.sv
`timescale 1ns/1ps
`default_nettype none
// Two-flop synchroniser with rising edge pulse
module act_edge_det
  import act_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic din,
  output logic      rise
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  // Only s2_r and s3_r feed the edge compare; s1_r may be metastable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  assign rise = s2_r & ~s3_r;
endmodule
`default_nettype wire

// ===== test/act_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ------
// Port checks
// ------
module act_asserts
  import act_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        aux_osc_input,
  input wire logic        aux_osc_output,
  input wire logic        aux_osc_output_en_n,
  input wire logic        cmp_match_a,
  input wire logic        cmp_match_b,
  input wire logic        wake,
  input wire logic        irq
);
  logic [4:0] ctl_r;
  logic       msk_r;
  logic       wr;
  logic       rd;
  logic       hit;
  assign wr  = psel && penable && pwrite;
  assign rd  = psel && penable && !pwrite;
  assign hit = paddr inside {ACT_OFF_CTRL, ACT_OFF_LOW, ACT_OFF_HIGH, ACT_OFF_STAT, ACT_OFF_MASK,
                             ACT_OFF_CMPA, ACT_OFF_CMPB};
  // Shadow of control, since the mode bits are not on the pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_r <= ACT_CTRL_RST;
      msk_r <= 1'b0;
    end else begin
      if (wr && paddr == ACT_OFF_CTRL) ctl_r <= pwdata[4:0];
      if (wr && paddr == ACT_OFF_MASK) msk_r <= pwdata[ACT_B_OVF];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_bad_addr: assert property (psel && penable |-> pslverr == !hit)
    else $error("pslverr does not follow address map");
  a_bad_read: assert property (rd && !hit |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_ctrl_read: assert property (rd && paddr == ACT_OFF_CTRL |-> prdata[4:0] == ctl_r)
    else $error("control readback wrong");
  a_osc_enable: assert property (aux_osc_output_en_n == !ctl_r[ACT_B_OSCEN])
    else $error("oscillator enable mismatch");
  a_osc_drive: assert property (!aux_osc_output_en_n |-> aux_osc_output == !aux_osc_input)
    else $error("amplifier output wrong");
  a_async_cmp: assert property (ctl_r[ACT_B_CS] && ctl_r[ACT_B_BYPASS] |-> !cmp_match_a && !cmp_match_b)
    else $error("compare active in async mode");
  a_wake_sleep: assert property (wake == (irq && ctl_r[ACT_B_SLEEP]))
    else $error("wake wrong");
  a_mask_off: assert property (wr && paddr == ACT_OFF_MASK && !pwdata[0] |=> !irq [*2])
    else $error("masked interrupt still high");
  a_irq_masked: assert property (!msk_r |-> !irq)
    else $error("interrupt high while masked");
  a_err_idle: assert property (!(psel && penable) |-> !pslverr)
    else $error("pslverr outside access phase");
  a_osc_off: assert property (aux_osc_output_en_n |-> !aux_osc_output)
    else $error("amplifier output active while disabled");
endmodule
bind act_timer act_asserts i_act_asserts (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pslverr, .aux_osc_input, .aux_osc_output, .aux_osc_output_en_n, .cmp_match_a, .cmp_match_b, .wake, .irq);
`default_nettype wire

// ===== test/act_osc_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------
// Count source
// ------
module act_osc_model (
  input  wire logic use_osc,
  output logic      ext_pin,
  output logic      osc_pin
);
  // Lines rest low between frames, no free-running clock
  initial begin
    ext_pin = 1'b0;
    osc_pin = 1'b0;
  end
  // Frame of k edges; 7 ns skew keeps edges off the bus clock
  task automatic burst(input int k, input int half);
    #7;
    repeat (k) begin
      if (use_osc) osc_pin = 1'b1;
      else ext_pin = 1'b1;
      #(half);
      osc_pin = 1'b0;
      ext_pin = 1'b0;
      #(half);
    end
  endtask
endmodule
`default_nettype wire

// ===== test/act_timer_test.sv
`timescale 1ns/1ps
`default_nettype none
// ------
// Bench
// ------
module act_timer_test;
  import act_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic        pready, pslverr, err, use_osc = 1'b0, ext_pin, osc_pin, osc_out, osc_en_n, ma, mb, wake, irq;
  logic [15:0] st, v;
  // Modes: synced, async in sleep, oscillator, synced in sleep (stalls)
  logic [4:0]  mode [4] = '{5'h03, 5'h17, 5'h0B, 5'h13};
  int          seed = 32'h3C030EAF, n, k, error_cnt = 0, checked = 0;
  always #12.5 pclk = ~pclk;
  act_timer i_act_timer (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .ext_count_input(ext_pin), .aux_osc_input(osc_pin), .aux_osc_output(osc_out),
    .aux_osc_output_en_n(osc_en_n), .cmp_match_a(ma), .cmp_match_b(mb), .wake, .irq);
  act_osc_model i_act_osc_model (.use_osc, .ext_pin, .osc_pin);
  // One APB transfer; waits on pready, never on a cycle count
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wc(input logic [15:0] d);
    bus(1'b1, ACT_OFF_LOW, {24'h0, d[7:0]});
    bus(1'b1, ACT_OFF_HIGH, {24'h0, d[15:8]});
  endtask
  // High, low, high again; retry if the low byte rolled over
  task automatic rc(output logic [15:0] d);
    logic [7:0] h;
    do begin
      bus(1'b0, ACT_OFF_HIGH, 32'h0);
      h = rdat[7:0];
      bus(1'b0, ACT_OFF_LOW, 32'h0);
      d = {h, rdat[7:0]};
      bus(1'b0, ACT_OFF_HIGH, 32'h0);
    end while (rdat[7:0] !== h);
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %0t seen %h exp %h", $time, s, e);
    end
  endtask
  function automatic logic [15:0] exp_cnt(logic [15:0] s, int k, int p);
    return (p == 0) ? 16'(s + k) : 16'((s + k) % p);
  endfunction
  function automatic logic ovf(logic [15:0] s, int k);
    return (s + k) > 32'hFFFF;
  endfunction
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Watchdog, far beyond the few tens of microseconds needed
  initial begin
    #500us;
    error_cnt++;
    end_of_test();
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      bus(1'b0, 12'(i * 4), 32'h0);
      if (i != 1 && i != 2) chk(rdat, 32'h0);
    end
    bus(1'b1, 12'h01C, 32'hFFFFFFFF);
    bus(1'b0, 12'h01C, 32'h0);
    chk({err, rdat[30:0]}, 32'h80000000);
    $display("register test done");
    bus(1'b1, ACT_OFF_MASK, 32'h1);
    for (int i = 0; i < 4; i++) begin
      n = 1 + ($random(seed) & 15);
      k = (i == 3) ? 0 : n;
      st = (i == 2) ? 16'($random(seed)) : 16'hFFF4;
      use_osc = (i == 2);
      bus(1'b1, ACT_OFF_CTRL, {27'h0, mode[i] & 5'h1E});
      if (i == 2) repeat (40) @(posedge pclk);
      wc(st);
      bus(1'b1, ACT_OFF_CTRL, {27'h0, mode[i]});
      i_act_osc_model.burst(n, 100);
      repeat (8) @(posedge pclk);
      bus(1'b1, ACT_OFF_CTRL, {27'h0, mode[i] & 5'h1E});
      rc(v);
      chk({16'h0, v}, {16'h0, exp_cnt(st, k, 0)});
      chk({31'h0, irq}, {31'h0, ovf(st, k)});
      chk({31'h0, wake}, {31'h0, ovf(st, k) & (i == 1)});
      bus(1'b1, ACT_OFF_STAT, 32'h1);
      // Flag clears on the accepting edge; look once it has settled
      @(negedge pclk);
      chk({31'h0, irq}, 32'h0);
      $display("count test %0d done", i);
    end
    bus(1'b1, ACT_OFF_MASK, 32'h0);
    use_osc = 1'b0;
    // Trigger reset: both units, then the async case where it is gated
    for (int u = 0; u < 3; u++) begin
      bus(1'b1, ACT_OFF_CTRL, 32'h0);
      bus(1'b1, (u == 1) ? ACT_OFF_CMPB : ACT_OFF_CMPA, {12'h0, ACT_MODE_SPECIAL, 16'h0005});
      wc(16'h0000);
      bus(1'b1, ACT_OFF_CTRL, (u == 2) ? 32'h7 : 32'h3);
      i_act_osc_model.burst(7, 100);
      repeat (8) @(posedge pclk);
      bus(1'b1, ACT_OFF_CTRL, 32'h0);
      rc(v);
      chk({16'h0, v}, {16'h0, exp_cnt(16'h0, 7, (u == 2) ? 0 : 5)});
      bus(1'b0, ACT_OFF_STAT, 32'h0);
      chk(rdat, 32'h0);
      // Plain compare on the stopped count: only the written unit matches
      bus(1'b1, (u == 1) ? ACT_OFF_CMPB : ACT_OFF_CMPA, {16'h0, v});
      @(negedge pclk);
      chk({30'h0, ma, mb}, (u == 1) ? 32'h1 : 32'h2);
      bus(1'b1, (u == 1) ? ACT_OFF_CMPB : ACT_OFF_CMPA, 32'h0);
      $display("trigger test %0d done", u);
    end
    end_of_test();
  end
endmodule
`default_nettype wire
